// ---- dv/dbm_lsu_model.sv ----
// load/store pipeline model: offers references and instruction hits
`timescale 1ns/1ps
`default_nettype none

module dbm_lsu_model
  import dbm_pkg::*;
(
  input  wire logic   i_mclk,
  output var dbm_ref_t o_ref,
  output logic        o_ibp_hit
);
  initial begin
    o_ref     = '0;
    o_ibp_hit = 1'b0;
  end

  // one reference for one cycle, after an optional stall; released bus shows the inverse with valid low
  task automatic send(input dbm_ref_t r, input int gap);
    repeat (gap) @(posedge i_mclk);
    @(posedge i_mclk);
    o_ref <= r;
    @(posedge i_mclk);
    o_ref <= {1'b0, ~r[$bits(dbm_ref_t)-2:0]};
  endtask

  // fetch unit reports one qualified instruction hit
  task automatic ibp();
    @(posedge i_mclk);
    o_ibp_hit <= 1'b1;
    @(posedge i_mclk);
    o_ibp_hit <= 1'b0;
  endtask
endmodule

`default_nettype wire

// ---- dv/testbench.sv ----
// self-checking bench of the data breakpoint block
`timescale 1ns/1ps
`default_nettype none
`include "dbm_defines.svh"
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin n_fail++; $display("ERROR %s exp %h got %h", n, e, g); end end

module testbench
  import dbm_pkg::*;
;
  logic             mclk, rst_n, awv, wv, bready, arv, rready, m_lvl, h, ibp_w;
  logic [7:0]       awaddr, araddr;
  logic [31:0]      wdata, m_ctrl, m_watch, m_fa, m_fc;
  wire logic        awready, wready, bvalid, arready, rvalid, dsi, ibpt, pin;
  wire logic [1:0]  bresp, rresp;
  wire logic [31:0] rdata, fcause, faddr;
  dbm_ref_t         r, ref_w;
  int               n_fail, comparisons, cyc, kind;

  dbm_lsu_model i_dbm_lsu_model (.i_mclk(mclk), .o_ref(ref_w), .o_ibp_hit(ibp_w));

  dbm_data_bp i_dbm_data_bp (.i_mclk(mclk), .i_rst_n(rst_n), .i_ce(1'b1),
    .i_awvalid(awv), .o_awready(awready), .i_awaddr(awaddr), .i_wvalid(wv), .o_wready(wready),
    .i_wdata(wdata), .i_wstrb(4'hF), .o_bvalid(bvalid), .i_bready(bready), .o_bresp(bresp),
    .i_arvalid(arv), .o_arready(arready), .i_araddr(araddr), .o_rvalid(rvalid),
    .i_rready(rready), .o_rdata(rdata), .o_rresp(rresp), .i_ref(ref_w), .i_ibp_hit(ibp_w),
    .o_dsi_req(dsi), .o_ibp_trap(ibpt), .o_fault_cause(fcause), .o_fault_addr(faddr),
    .o_pulse_pin(pin));

  // clock and hang guard
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cyc++;
    if (cyc > 20000) begin
      n_fail++;
      end_sim();
    end
  end

  task automatic end_sim();
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // register write: address and data released each when taken
  task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge mclk);
    awaddr <= a;
    wdata <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge mclk);
      if (awready) awv <= 1'b0;
      if (wready) wv <= 1'b0;
    end while (!bvalid);
    bready <= 1'b0;
    `CHK("bresp", er, bresp)
  endtask

  task automatic axr(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    @(posedge mclk);
    araddr <= a;
    arv <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge mclk);
      if (arready) arv <= 1'b0;
    end while (!rvalid);
    rready <= 1'b0;
    `CHK("rdata", ed, rdata)
    `CHK("rresp", er, rresp)
  endtask

  // reference model of one data breakpoint decision
  function automatic logic exp_hit(dbm_ref_t x);
    logic [31:0] b, f;
    int          n;
    logic        st, any;
    f = x.blk_zero ? (x.ea & ~32'h1F) : x.ea;
    n = x.blk_zero ? 32 : int'(x.nbytes);
    st = x.store | x.blk_zero;
    any = 1'b0;
    for (int i = 0; i < n; i++) begin
      b = f + 32'(i);
      if (b[31:3] == m_watch[31:3] && ((b[2:0] ^ m_watch[2:0]) & m_ctrl[8:6]) == 3'h0) any = 1'b1;
    end
    if (x.cache_op && !x.blk_zero) any = 1'b0;
    if (x.xlate != m_ctrl[2]) any = 1'b0;
    if (!(x.user ? m_ctrl[4] : m_ctrl[3])) any = 1'b0;
    if (!((x.load && m_ctrl[0]) || (st && m_ctrl[1]))) any = 1'b0;
    return x.valid & any & ~x.higher_trap;
  endfunction

  // pin watch after a trigger edge: pulse at edges 4 and 5 only, never a trap
  task automatic pin_chk(input int k0, input logic pulse);
    for (int k = k0; k <= 7; k++) begin
      @(posedge mclk);
      #1;
      `CHK("pin", (pulse && (k == 4 || k == 5)) ? ~m_lvl : m_lvl, pin)
      `CHK("trap", 2'b00, {dsi, ibpt})
    end
  endtask

  initial begin
    {awv, wv, bready, arv, rready, awaddr, araddr, wdata} = '0;
    {m_ctrl, m_watch, m_fa, m_fc, m_lvl} = '0;
    rst_n = 1'b0;
    void'($urandom(32'h08EE8B7C));
    repeat (12) @(posedge mclk);
    rst_n <= 1'b1;
    axr(`DBM_OFS_CTRL, 32'h0, `DBM_RESP_OKAY);
    axr(`DBM_OFS_L2PIN, 32'h0, `DBM_RESP_OKAY);
    axr(8'h3C, 32'h0, `DBM_RESP_SLVERR);
    axw(8'h3C, 32'h1, `DBM_RESP_SLVERR);
    axw(`DBM_OFS_WATCH, 32'hFFFF_FFFF, `DBM_RESP_OKAY);
    axr(`DBM_OFS_WATCH, 32'hFFFF_FFFF, `DBM_RESP_OKAY);
    axw(`DBM_OFS_CTRL, 32'hFFFF_FFFF, `DBM_RESP_OKAY);
    axr(`DBM_OFS_CTRL, 32'h0000_01FF, `DBM_RESP_OKAY);
    axw(`DBM_OFS_COMPAT, 32'h1234_5675, `DBM_RESP_OKAY);
    axr(`DBM_OFS_WATCH, 32'h1234_5670, `DBM_RESP_OKAY);
    axr(`DBM_OFS_CTRL, 32'h0000_01FD, `DBM_RESP_OKAY);
    axr(`DBM_OFS_COMPAT, 32'h1234_5675, `DBM_RESP_OKAY);
    // random references against the model, trap mode
    for (int i = 0; i < 400; i++) begin
      if (i % 25 == 0) begin
        m_ctrl = ($urandom & 32'h1C7) | ((i % 100) ? 32'h18 : 32'h0);
        m_watch = $urandom;
        axw(`DBM_OFS_CTRL, m_ctrl, `DBM_RESP_OKAY);
        axw(`DBM_OFS_WATCH, m_watch, `DBM_RESP_OKAY);
      end
      kind = $urandom % 5;
      r.valid = ($urandom % 8) != 0;
      r.ea = ($urandom % 4) ? (m_watch ^ ($urandom & 32'h3F)) - 32'h4 : $urandom;
      r.nbytes = 4'(1 + $urandom % 8);
      r.load = kind == 0 || kind == 3; // kind 3 is a plain cache operation that reads
      r.store = kind == 1 || kind == 4; // kind 4 is a conditional store that fails
      r.blk_zero = kind == 2;
      r.cache_op = kind == 2 || kind == 3;
      r.xlate = 1'($urandom);
      r.user = 1'($urandom);
      r.higher_trap = ($urandom % 8) == 0;
      h = exp_hit(r);
      i_dbm_lsu_model.send(r, $urandom % 2);
      #1;
      if (h) begin
        m_fa = r.ea;
        m_fc = `DBM_FCAUSE_BP;
      end
      `CHK("dsi", h, dsi)
      `CHK("faddr", m_fa, faddr)
      `CHK("fcause", m_fc, fcause)
    end
    // pin mode: last byte of a 5-byte load hits the watch word exactly
    axw(`DBM_OFS_L2PIN, 32'h1, `DBM_RESP_OKAY);
    m_lvl = 1'b1;
    axw(`DBM_OFS_WATCH, 32'h0000_0100, `DBM_RESP_OKAY);
    axw(`DBM_OFS_CTRL, 32'h0000_01FB, `DBM_RESP_OKAY);
    r = '0;
    r.valid = 1'b1;
    r.ea = 32'h0000_00FC;
    r.nbytes = 4'h5;
    r.load = 1'b1;
    i_dbm_lsu_model.send(r, 0);
    pin_chk(1, 1'b1);
    i_dbm_lsu_model.send(r, 0);
    i_dbm_lsu_model.send(r, 0);
    pin_chk(3, 1'b1);
    r.higher_trap = 1'b1;
    i_dbm_lsu_model.send(r, 0);
    pin_chk(1, 1'b0);
    i_dbm_lsu_model.ibp();
    pin_chk(1, 1'b1);
    axw(`DBM_OFS_CTRL, 32'h0000_0003, `DBM_RESP_OKAY);
    i_dbm_lsu_model.ibp();
    #1;
    `CHK("ibp_trap", 1'b1, ibpt)
    axw(`DBM_OFS_FCAUSE, 32'hFFFF_FFFF, `DBM_RESP_OKAY);
    axr(`DBM_OFS_FCAUSE, m_fc, `DBM_RESP_OKAY);
    axr(`DBM_OFS_FADDR, m_fa, `DBM_RESP_OKAY);
    end_sim();
  end
endmodule

`default_nettype wire

// ---- logic/dbm_byte_hit.sv ----
// byte-wise compare of a reference's byte range against the masked watch address
`timescale 1ns/1ps
`default_nettype none

module dbm_byte_hit (
  input  wire logic [31:0] i_first,
  input  wire logic [31:0] i_last,
  input  wire logic [31:0] i_watch,
  input  wire logic [2:0]  i_low_sel,
  output logic             o_hit
);

  // walk the eight bytes of the watched doubleword; any touched, eligible byte hits
  always_comb begin
    logic [31:0] byte_addr;
    byte_addr = 32'h0;
    o_hit     = 1'b0;
    for (int b = 0; b < 8; b++) begin
      byte_addr = {i_watch[31:3], 3'(b)};
      if ((byte_addr >= i_first) && (byte_addr <= i_last) &&
          (((3'(b) ^ i_watch[2:0]) & i_low_sel) == 3'h0)) begin
        o_hit = 1'b1;
      end
    end
  end

endmodule

`default_nettype wire

// ---- logic/dbm_data_bp.sv ----
// data address breakpoint: watch registers, match and qualification, trap or pin pulse
//
// The address map and the AXI4-Lite interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "dbm_defines.svh"

// How it works
// - high address bits exact, low bits under mask
// - mask seven exact, mask zero whole doubleword
// - any touched byte of the reference may match
// - block zero is a store of 32 bytes
// - other cache operations never hit
// - translation state must equal xlate_required
// - user or kernel enable must suit privilege
// - loads need read enable, stores write enable
// - both enables of a pair clear disables
// - failed conditional store may still hit
// - hit raises storage fault, cause and address
// - pin mode: no trap, delayed inverted pulse
// - close hits may merge into one pulse
// - pulse only where trap would be taken
// - breakpoint ranks below every other fault
// - mask and privilege ignore instruction breakpoints
// - pin mode redirects instruction hits too
// - wide reference may partly complete first
// - control fields at their fixed bit positions
// - holds a 32-bit watch address
// - compat write loads address and types, sets both privileges
// - compat read merges address and type bits
module dbm_data_bp
  import dbm_pkg::*;
#(
  parameter int unsigned AW        = 8,
  parameter int unsigned BUS_RATIO = `DBM_BUS_RATIO,
  parameter int unsigned PIN_DELAY = `DBM_PIN_DELAY_BUS
) (
  input  wire logic          i_mclk,
  input  wire logic          i_rst_n,
  input  wire logic          i_ce,
  input  wire logic          i_awvalid,
  output logic               o_awready,
  input  wire logic [AW-1:0] i_awaddr,
  input  wire logic          i_wvalid,
  output logic               o_wready,
  input  wire logic [31:0]   i_wdata,
  input  wire logic [3:0]    i_wstrb,
  output logic               o_bvalid,
  input  wire logic          i_bready,
  output logic [1:0]         o_bresp,
  input  wire logic          i_arvalid,
  output logic               o_arready,
  input  wire logic [AW-1:0] i_araddr,
  output logic               o_rvalid,
  input  wire logic          i_rready,
  output logic [31:0]        o_rdata,
  output logic [1:0]         o_rresp,
  input  wire dbm_ref_t      i_ref,
  input  wire logic          i_ibp_hit,
  output logic               o_dsi_req,
  output logic               o_ibp_trap,
  output logic [31:0]        o_fault_cause,
  output logic [31:0]        o_fault_addr,
  output logic               o_pulse_pin
);

  if (AW < 8) begin : g_bad_aw
    $error("dbm_data_bp: address width must be at least eight bits");
  end
  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (!i_rst_n);
  // architectural state
  dbm_ctrl_t   ctrl_q;
  logic [31:0] watch_q;
  logic [31:0] fcause_q;
  logic [31:0] faddr_q;
  logic        l2pin_q;
  logic        dsi_q;
  logic        ibp_trap_q;
  // bus channel state
  logic        awready_q;
  logic        wready_q;
  logic        bvalid_q;
  logic [1:0]  bresp_q;
  logic        arready_q;
  logic        rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0]  rresp_q;
  logic [7:0]  wr_key_q;
  logic [31:0] wdata_q;
  logic [3:0]  wstrb_q;
  // match path
  logic [31:0] ref_first;
  logic [31:0] ref_last;
  logic        addr_hit;
  logic        is_store;
  logic        plain_cache;
  logic        type_ok;
  logic        priv_ok;
  logic        xlate_ok;
  logic        data_hit;
  logic        bp_taken;
  logic        pin_trigger;
  // register write and read path
  logic        wr_fire;
  logic [32:0] wr_view;
  logic [32:0] rd_view;
  logic [31:0] wmerge;
  logic [7:0]  rd_key;
  // register read view: error flag above the word; reserved and unused bits read zero
  function automatic logic [32:0] reg_view(input logic [7:0] key);
    case (key)
      `DBM_OFS_CTRL:   reg_view = {1'b0, 23'h0, ctrl_q};
      `DBM_OFS_WATCH:  reg_view = {1'b0, watch_q};
      `DBM_OFS_COMPAT: reg_view = {1'b0, watch_q[31:`DBM_COMPAT_LOW], ctrl_q.xlate_req,
                                   ctrl_q.wr_en, ctrl_q.rd_en};
      `DBM_OFS_FCAUSE: reg_view = {1'b0, fcause_q};
      `DBM_OFS_FADDR:  reg_view = {1'b0, faddr_q};
      `DBM_OFS_L2PIN:  reg_view = {1'b0, 31'h0, l2pin_q};
      default:         reg_view = {1'b1, 32'h0};
    endcase
  endfunction
  // word-aligned keys; the low two address bits never select anything
  assign rd_key  = {i_araddr[7:2], 2'h0};
  assign rd_view = reg_view(rd_key);
  assign wr_view = reg_view(wr_key_q);
  assign wr_fire = ~awready_q & ~wready_q & ~bvalid_q;
  // byte lanes without a strobe keep what the register shows now
  always_comb begin
    wmerge = wr_view[31:0];
    for (int i = 0; i < 4; i++) begin
      if (wstrb_q[i]) begin
        wmerge[8*i +: 8] = wdata_q[8*i +: 8];
      end
    end
  end
  // write address channel: one write under way, reopened when the answer is taken
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      awready_q <= 1'b1;
      wr_key_q  <= 8'h00;
    end else if (i_ce) begin
      if (i_awvalid && awready_q) begin
        awready_q <= 1'b0;
        wr_key_q  <= {i_awaddr[7:2], 2'h0};
      end else if (bvalid_q && i_bready) begin
        awready_q <= 1'b1;
      end
    end
  end

  // write data channel, taken independently of the address
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      wready_q <= 1'b1;
      wdata_q  <= 32'h0;
      wstrb_q  <= 4'h0;
    end else if (i_ce) begin
      if (i_wvalid && wready_q) begin
        wready_q <= 1'b0;
        wdata_q  <= i_wdata;
        wstrb_q  <= i_wstrb;
      end else if (bvalid_q && i_bready) begin
        wready_q <= 1'b1;
      end
    end
  end

  // write answer once both halves are held; unmapped keys answer with an error
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      bvalid_q <= 1'b0;
      bresp_q  <= `DBM_RESP_OKAY;
    end else if (i_ce) begin
      if (wr_fire) begin
        bvalid_q <= 1'b1;
        bresp_q  <= wr_view[32] ? `DBM_RESP_SLVERR : `DBM_RESP_OKAY;
      end else if (bvalid_q && i_bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  // read channel: data captured at the address edge, one read under way
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      arready_q <= 1'b1;
      rvalid_q  <= 1'b0;
      rdata_q   <= 32'h0;
      rresp_q   <= `DBM_RESP_OKAY;
    end else if (i_ce) begin
      if (i_arvalid && arready_q) begin
        arready_q <= 1'b0;
        rvalid_q  <= 1'b1;
        rdata_q   <= rd_view[31:0];
        rresp_q   <= rd_view[32] ? `DBM_RESP_SLVERR : `DBM_RESP_OKAY;
      end else if (rvalid_q && i_rready) begin
        rvalid_q  <= 1'b0;
        arready_q <= 1'b1;
      end
    end
  end

  // control register: direct write keeps only defined fields, compat write forces privileges
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      ctrl_q <= dbm_ctrl_t'(`DBM_CTRL_RESET);
    end else if (i_ce && wr_fire) begin
      if (wr_key_q == `DBM_OFS_CTRL) begin
        ctrl_q <= dbm_ctrl_t'(wmerge[`DBM_CTL_MASK_MSB:0]);
      end else if (wr_key_q == `DBM_OFS_COMPAT) begin
        ctrl_q.xlate_req <= wmerge[`DBM_CTL_XL_BIT];
        ctrl_q.wr_en     <= wmerge[`DBM_CTL_WR_BIT];
        ctrl_q.rd_en     <= wmerge[`DBM_CTL_RD_BIT];
        ctrl_q.user_en   <= 1'b1;
        ctrl_q.kern_en   <= 1'b1;
      end
    end
  end

  // watch address; new values steer matching from the next cycle, software orders the rest
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      watch_q <= `DBM_WATCH_RESET;
    end else if (i_ce && wr_fire) begin
      if (wr_key_q == `DBM_OFS_WATCH) begin
        watch_q <= wmerge;
      end else if (wr_key_q == `DBM_OFS_COMPAT) begin
        watch_q <= {wmerge[31:`DBM_COMPAT_LOW], 3'h0};
      end
    end
  end

  // idle level of the pulse pin, owned by the level2 control copy here
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      l2pin_q <= `DBM_L2PIN_RESET;
    end else if (i_ce && wr_fire && (wr_key_q == `DBM_OFS_L2PIN)) begin
      l2pin_q <= wmerge[0];
    end
  end

  // byte range touched; block zero covers its whole aligned block
  always_comb begin
    if (i_ref.blk_zero) begin
      ref_first = {i_ref.ea[31:`DBM_BLK_LSB], 5'h00};
      ref_last  = {i_ref.ea[31:`DBM_BLK_LSB], 5'h1F};
    end else begin
      ref_first = i_ref.ea;
      ref_last  = i_ref.ea + {28'h0, i_ref.nbytes} - 32'h1;
    end
  end

  dbm_byte_hit u_byte_hit (
    .i_first   (ref_first),
    .i_last    (ref_last),
    .i_watch   (watch_q),
    .i_low_sel (ctrl_q.low_sel),
    .o_hit     (addr_hit)
  );

  // qualifiers; a conditional store counts as a store whether or not it is performed
  assign is_store    = i_ref.store | i_ref.blk_zero;
  assign plain_cache = i_ref.cache_op & ~i_ref.blk_zero;
  assign type_ok     = (i_ref.load & ctrl_q.rd_en) | (is_store & ctrl_q.wr_en);
  assign priv_ok     = (i_ref.user & ctrl_q.user_en) | (~i_ref.user & ctrl_q.kern_en);
  assign xlate_ok    = (i_ref.xlate == ctrl_q.xlate_req);
  assign data_hit    = i_ref.valid & addr_hit & type_ok & priv_ok & xlate_ok & ~plain_cache;
  assign bp_taken    = data_hit & ~i_ref.higher_trap;

  // instruction hits arrive already matched; mask and privilege never reach them
  assign pin_trigger = ctrl_q.pin_sel & (bp_taken | i_ibp_hit);

  // trap requests, pulsed one cycle; the pipeline may already have finished part of a wide access
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      dsi_q      <= 1'b0;
      ibp_trap_q <= 1'b0;
    end else if (i_ce) begin
      dsi_q      <= bp_taken & ~ctrl_q.pin_sel;
      ibp_trap_q <= i_ibp_hit & ~ctrl_q.pin_sel;
    end
  end

  // fault cause and address captured only for a taken data breakpoint trap
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      fcause_q <= `DBM_FCAUSE_RESET;
      faddr_q  <= `DBM_FADDR_RESET;
    end else if (i_ce && bp_taken && !ctrl_q.pin_sel) begin
      fcause_q <= `DBM_FCAUSE_BP;
      faddr_q  <= i_ref.ea;
    end
  end

  dbm_pin_pulse #(
    .RATIO     (BUS_RATIO),
    .DELAY_BUS (PIN_DELAY)
  ) u_pin_pulse (
    .i_mclk    (i_mclk),
    .i_rst_n   (i_rst_n),
    .i_ce      (i_ce),
    .i_trigger (pin_trigger),
    .i_level   (l2pin_q),
    .o_pin     (o_pulse_pin)
  );

  assign o_awready     = awready_q;
  assign o_wready      = wready_q;
  assign o_bvalid      = bvalid_q;
  assign o_bresp       = bresp_q;
  assign o_arready     = arready_q;
  assign o_rvalid      = rvalid_q;
  assign o_rdata       = rdata_q;
  assign o_rresp       = rresp_q;
  assign o_dsi_req     = dsi_q;
  assign o_ibp_trap    = ibp_trap_q;
  assign o_fault_cause = fcause_q;
  assign o_fault_addr  = faddr_q;

  // qualification checks on the match path
  a_disabled_quiet: assert property (
    ((!ctrl_q.rd_en && !ctrl_q.wr_en) || (!ctrl_q.user_en && !ctrl_q.kern_en)) |-> !data_hit)
    else $error("breakpoint hit while disabled");
  a_cache_op_quiet: assert property (
    (i_ref.cache_op && !i_ref.blk_zero) |-> !data_hit)
    else $error("cache operation raised a breakpoint");
  a_xlate_qual: assert property (
    ($past(i_ce) && o_dsi_req) |-> ($past(i_ref.xlate) == $past(ctrl_q.xlate_req)))
    else $error("hit with wrong translation state");
  a_priv_qual: assert property (
    ($past(i_ce) && o_dsi_req) |-> (($past(i_ref.user) && $past(ctrl_q.user_en)) || (!$past(i_ref.user) && $past(ctrl_q.kern_en))))
    else $error("hit with privilege not enabled");
  a_type_qual: assert property (
    ($past(i_ce) && o_dsi_req) |-> (($past(i_ref.load) && $past(ctrl_q.rd_en)) ||
      (($past(i_ref.store) || $past(i_ref.blk_zero)) && $past(ctrl_q.wr_en))))
    else $error("hit with access type not enabled");
  a_exact_match: assert property (
    (data_hit && (ctrl_q.low_sel == 3'h7) && (i_ref.nbytes == 4'h1) && !i_ref.blk_zero)
      |-> (i_ref.ea == watch_q))
    else $error("exact mask hit on another byte");
  a_dword_match: assert property (
    (data_hit && !i_ref.blk_zero && (({2'b0, i_ref.ea[2:0]} + {1'b0, i_ref.nbytes}) <= 5'h08))
      |-> (i_ref.ea[31:3] == watch_q[31:3]))
    else $error("hit outside watched doubleword");
  a_blk_zero_hit: assert property (
    (i_ref.valid && i_ref.blk_zero && (i_ref.ea[31:5] == watch_q[31:5]) && ctrl_q.wr_en && priv_ok &&
     xlate_ok) |-> data_hit)
    else $error("block zero missed its block");
  // consequences at the outputs
  a_dsi_capture: assert property (
    ($past(i_ce) && o_dsi_req) |-> ((o_fault_cause == `DBM_FCAUSE_BP) && (o_fault_addr == $past(i_ref.ea))))
    else $error("fault cause or address not captured");
  a_pin_no_trap: assert property (
    ($past(i_ce) && $past(ctrl_q.pin_sel)) |-> (!o_dsi_req && !o_ibp_trap))
    else $error("trap raised in pin mode");
  a_higher_trap: assert property (
    ($past(i_ce) && $past(i_ref.higher_trap)) |-> (!o_dsi_req && !($past(pin_trigger) && !$past(i_ibp_hit))))
    else $error("breakpoint outranked a higher fault");
  a_compat_write: assert property (
    (i_ce && wr_fire && (wr_key_q == `DBM_OFS_COMPAT))
      |=> (ctrl_q.user_en && ctrl_q.kern_en && (watch_q[2:0] == 3'h0)))
    else $error("compat write did not set privileges");

endmodule

`default_nettype wire

// ---- logic/dbm_defines.svh ----
// register offsets, field positions, reset values and timing counts of the data breakpoint block
`ifndef DBM_DEFINES_SVH
`define DBM_DEFINES_SVH

// register byte offsets on the register bus
`define DBM_OFS_CTRL      8'h00
`define DBM_OFS_WATCH     8'h04
`define DBM_OFS_COMPAT    8'h08
`define DBM_OFS_FCAUSE    8'h0C
`define DBM_OFS_FADDR     8'h10
`define DBM_OFS_L2PIN     8'h14

// control fields, little-endian positions (bit 31 of the big-endian layout is bit 0 here)
`define DBM_CTL_RD_BIT    0
`define DBM_CTL_WR_BIT    1
`define DBM_CTL_XL_BIT    2
`define DBM_CTL_KERN_BIT  3
`define DBM_CTL_USER_BIT  4
`define DBM_CTL_PIN_BIT   5
`define DBM_CTL_MASK_LSB  6
`define DBM_CTL_MASK_MSB  8
`define DBM_COMPAT_LOW    3

// reset values
`define DBM_CTRL_RESET    9'h000
`define DBM_WATCH_RESET   32'h0000_0000
`define DBM_FCAUSE_RESET  32'h0000_0000
`define DBM_FADDR_RESET   32'h0000_0000
`define DBM_L2PIN_RESET   1'b0

// fault cause value of a breakpoint: big-endian bit 9 is bit 22 here
`define DBM_FCAUSE_BP     32'h0040_0000

// block zero covers one aligned 32-byte cache block
`define DBM_BLK_LSB       5

// pin pulse timing: processor cycles per bus cycle, bus cycles before the pulse
`define DBM_BUS_RATIO     2
`define DBM_PIN_DELAY_BUS 2

// bus answers
`define DBM_RESP_OKAY     2'h0
`define DBM_RESP_SLVERR   2'h2

`endif

// ---- logic/dbm_pin_pulse.sv ----
// delayed one-bus-cycle pulse on the breakpoint pin, merging hits that arrive meanwhile
`timescale 1ns/1ps
`default_nettype none
`include "dbm_defines.svh"

module dbm_pin_pulse #(
  parameter int unsigned RATIO     = `DBM_BUS_RATIO,
  parameter int unsigned DELAY_BUS = `DBM_PIN_DELAY_BUS
) (
  input  wire logic i_mclk,
  input  wire logic i_rst_n,
  input  wire logic i_ce,
  input  wire logic i_trigger,
  input  wire logic i_level,
  output logic      o_pin
);

  localparam int unsigned WAIT_CYC = RATIO * DELAY_BUS;
  localparam int unsigned CW       = $clog2(WAIT_CYC + RATIO + 1);

  if ((RATIO < 1) || (DELAY_BUS < 1)) begin : g_bad_cfg
    $error("dbm_pin_pulse: ratio and delay must both be at least one");
  end

  typedef enum logic [1:0] {DBM_PP_IDLE, DBM_PP_WAIT, DBM_PP_DRIVE} dbm_pp_state_t;

  dbm_pp_state_t state_q;
  logic [CW-1:0] cnt_q;
  logic          pin_q;

  // triggers while waiting or driving are absorbed into the pulse under way
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      state_q <= DBM_PP_IDLE;
      cnt_q   <= '0;
    end else if (i_ce) begin
      case (state_q)
        DBM_PP_IDLE: begin
          if (i_trigger) begin
            state_q <= DBM_PP_WAIT;
            cnt_q   <= CW'(WAIT_CYC - 1);
          end
        end
        DBM_PP_WAIT: begin
          if (cnt_q == '0) begin
            state_q <= DBM_PP_DRIVE;
            cnt_q   <= CW'(RATIO - 1);
          end else begin
            cnt_q <= cnt_q - 1'b1;
          end
        end
        DBM_PP_DRIVE: begin
          if (cnt_q == '0) begin
            state_q <= DBM_PP_IDLE;
          end else begin
            cnt_q <= cnt_q - 1'b1;
          end
        end
        default: begin
          state_q <= DBM_PP_IDLE;
        end
      endcase
    end
  end

  // inverted level for exactly one bus cycle, idle level otherwise
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      pin_q <= `DBM_L2PIN_RESET;
    end else if (i_ce) begin
      if (((state_q == DBM_PP_WAIT) && (cnt_q == '0)) ||
          ((state_q == DBM_PP_DRIVE) && (cnt_q != '0))) begin
        pin_q <= ~i_level;
      end else begin
        pin_q <= i_level;
      end
    end
  end

  assign o_pin = pin_q;

endmodule

`default_nettype wire

// ---- logic/dbm_pkg.sv ----
// types shared by the data breakpoint block
`default_nettype none

package dbm_pkg;

  // one reference offered by the load/store pipeline
  typedef struct packed {
    logic        valid;
    logic [31:0] ea;
    logic [3:0]  nbytes;
    logic        load;
    logic        store;
    logic        blk_zero;
    logic        cache_op;
    logic        xlate;
    logic        user;
    logic        higher_trap;
  } dbm_ref_t;

  // control register, packed in its own bit order (low_sel lands on bits 8:6)
  typedef struct packed {
    logic [2:0] low_sel;
    logic       pin_sel;
    logic       user_en;
    logic       kern_en;
    logic       xlate_req;
    logic       wr_en;
    logic       rd_en;
  } dbm_ctrl_t;

endpackage

`default_nettype wire
